// *** core/tcr_map.svh ***
// Constants shared by both ends of the temperature conversion link
`ifndef TCR_MAP_SVH
`define TCR_MAP_SVH
// Operation
// RQ1: Resolution selectable from 9 to 12 bits
// RQ2: Power-up resolution is twelve bits
// RQ3: Power up idle, no conversion uncommanded
// RQ4: Command 44h starts a conversion
// RQ5: Store result, then return to idle
// RQ6: Powered slots answer 0 busy, 1 done
// RQ7: Line-powered master holds pullup, never polls
// RQ8: Result is 16-bit two's complement, sign-extended
// RQ9: Bits 15 to 11 equal the sign
// RQ10: Weights 2^-4 at bit 0 upward
// RQ11: Low bits undefined below twelve bits
// RQ12: Twelve-bit conversion takes at most 400 ms
// RQ13: Limits, configuration and user bytes retained
// RQ14: Unique 64-bit code addresses each device
// RQ15: Data line driven only open-drain
// RQ16: Result reads +85 before first conversion
// RQ17: Pullup within 10 us, bus otherwise quiet

// Link commands
`define TCR_CMD_CONVERT 8'h44
`define TCR_CMD_READ 8'hbe
`define TCR_CMD_WRCFG 8'h4e

// Result and stored bytes
`define TCR_RESULT_RST 16'h0550
`define TCR_NV_RST 40'h000003807f
`define TCR_NV_CFG 2
`define TCR_RES_LSB 0
`define TCR_FRAME_LAST 6'h37

// Timing
`define TCR_TCONV_MS 400
`define TCR_TSPU_US 10
`define TCR_CLK_KHZ 40000

// Controller register offsets
`define TCR_REG_CTRL 8'h00
`define TCR_REG_ID_LO 8'h04
`define TCR_REG_ID_HI 8'h08
`define TCR_REG_CFG 8'h0c
`define TCR_REG_USER 8'h10
`define TCR_REG_STATUS 8'h14
`define TCR_REG_RESULT 8'h18
`define TCR_REG_INT_STAT 8'h1c
`define TCR_REG_INT_MASK 8'h20
`define TCR_REG_NVRD 8'h24

// Controller fields
`define TCR_CTRL_CONV 0
`define TCR_CTRL_READ 1
`define TCR_CTRL_WRCFG 2
`define TCR_CTRL_LINEPWR 3
`define TCR_INT_DONE 0
`define TCR_INT_RDDONE 1
`define TCR_CFG_RST 24'h03807f
`endif

// *** core/tcr_pkg.sv ***
// Types shared by both ends of the temperature conversion link
`default_nettype none
package tcr_pkg;
    typedef enum logic [0:0] {DEV_IDLE, DEV_CONV} tcr_dev_state_t;
    typedef enum logic [1:0] {ANS_NONE, ANS_BUSY, ANS_DATA} tcr_answer_t;
    typedef enum logic [2:0] {
        H_IDLE, H_CMD, H_POLL, H_PSAMP, H_SPU, H_RSLOT, H_RSAMP
    } tcr_host_state_t;
endpackage
`default_nettype wire

// *** core/tcr_link_if.sv ***
// Link between the bus master and the thermometer
`timescale 1ns/1ps
`default_nettype none
interface tcr_link_if;
    logic cmd_valid;
    logic [7:0] cmd_code;
    logic [63:0] cmd_id;
    logic [39:0] cmd_data;
    logic slot;
    logic strong_pullup;
    logic host_dq_o;
    logic host_dq_oe;
    logic dev_dq_o;
    logic dev_dq_oe;
    logic dq;

    // Weak pullup gives the high level unless someone pulls low
    assign dq = ~((host_dq_oe & ~host_dq_o) | (dev_dq_oe & ~dev_dq_o));

    modport dev (
        input cmd_valid, cmd_code, cmd_id, cmd_data, slot, strong_pullup, dq,
        output dev_dq_o, dev_dq_oe
    );
    modport host (
        output cmd_valid, cmd_code, cmd_id, cmd_data, slot, strong_pullup,
        output host_dq_o, host_dq_oe,
        input dq
    );
endinterface
`default_nettype wire

// *** core/tcr_dev.sv ***
// Thermometer end: conversion control, result formatting and slot answers
`timescale 1ns/1ps
`default_nettype none
`include "tcr_map.svh"
module tcr_dev #(
    // Arbitrary identity value; each device on a shared line needs its own
    parameter logic [63:0] DEV_ID = 64'h0123456789abcdef,
    parameter int CONV_CYCLES = `TCR_TCONV_MS * `TCR_CLK_KHZ,
    parameter int CNT_W = 24
) (
    // Clock and resets
    input wire logic clock_in,
    input wire logic reset_n_in,
    input wire logic nv_reset_n_in,
    // Link to the bus master
    tcr_link_if.dev link,
    // Sensor front end and supply sense
    input wire logic [11:0] sensor_in,
    input wire logic optional_supply_pin_in,
    // Status
    output logic converting_out,
    output logic line_powered_out,
    output logic starved_out,
    output logic [1:0] resolution_out,
    output logic [15:0] temperature_result_out
);
    localparam logic [39:0] NV_INIT = `TCR_NV_RST;
    localparam int GRACE_CYCLES = `TCR_TSPU_US * `TCR_CLK_KHZ / 1000;

    tcr_pkg::tcr_dev_state_t state_ff;
    tcr_pkg::tcr_dev_state_t nxt_state;
    tcr_pkg::tcr_answer_t ans_ff;
    tcr_pkg::tcr_answer_t nxt_ans;
    logic [CNT_W-1:0] cnt_ff;
    logic [CNT_W-1:0] nxt_cnt;
    logic [5:0] bit_ff;
    logic [5:0] nxt_bit;
    logic [15:0] result_ff;
    logic [15:0] nxt_result;
    logic oe_ff;
    logic nxt_oe;
    logic starved_ff;
    logic nxt_starved;
    logic line_pwr_ff;
    logic strap_done_ff;
    logic [7:0] nv_ff [0:4];

    // Command decode
    wire addressed = link.cmd_valid & (link.cmd_id == DEV_ID); // RQ14
    wire is_idle = (state_ff == tcr_pkg::DEV_IDLE);
    wire code_conv = (link.cmd_code == `TCR_CMD_CONVERT);
    wire code_read = (link.cmd_code == `TCR_CMD_READ);
    wire code_wrcfg = (link.cmd_code == `TCR_CMD_WRCFG);
    wire go_conv = addressed & code_conv & is_idle; // RQ4
    wire go_read = addressed & code_read;
    // Stored bytes stay frozen while converting so the resolution cannot shift mid-run
    wire go_wrcfg = addressed & code_wrcfg & is_idle;

    // Resolution and conversion length
    wire [1:0] res = nv_ff[`TCR_NV_CFG][`TCR_RES_LSB +: 2]; // RQ1
    wire [1:0] res_drop = 2'h3 - res;
    wire [CNT_W-1:0] conv_len = CNT_W'(CONV_CYCLES >> res_drop); // RQ12
    wire [CNT_W-1:0] elapsed = conv_len - 1'h1 - cnt_ff;
    wire conv_end = ~is_idle & (cnt_ff == '0);

    // A line-powered part without the strong pullup cannot finish; give up
    wire starve = ~is_idle & line_pwr_ff & ~link.strong_pullup
                & (elapsed >= CNT_W'(GRACE_CYCLES)); // RQ17

    // Result formatting
    wire [15:0] sign_ext = {{4{sensor_in[11]}}, sensor_in}; // RQ8 RQ9 RQ10
    wire [15:0] res_mask = 16'hffff << res_drop; // RQ11
    wire [15:0] fresh = sign_ext & res_mask;

    // Read frame, least significant bit first
    wire [55:0] frame = {nv_ff[4], nv_ff[3], nv_ff[2], nv_ff[1], nv_ff[0], result_ff};

    // Supply sense is caught once after power-up, like a strap
    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            strap_done_ff <= 1'h0;
            line_pwr_ff <= 1'h0;
        end else if (!strap_done_ff) begin
            strap_done_ff <= 1'h1;
            line_pwr_ff <= ~optional_supply_pin_in;
        end
    end

    // Stored bytes survive the power reset; only their own reset reloads their defaults
    always_ff @(posedge clock_in or negedge nv_reset_n_in) begin
        if (!nv_reset_n_in) begin
            for (int i = 0; i < 5; i++) begin
                nv_ff[i] <= NV_INIT[i*8 +: 8]; // RQ2
            end
        end else if (go_wrcfg) begin
            for (int i = 0; i < 5; i++) begin
                nv_ff[i] <= link.cmd_data[i*8 +: 8]; // RQ13
            end
        end
    end

    // Conversion sequencer
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        nxt_result = result_ff;
        nxt_starved = starved_ff;
        case (state_ff)
            tcr_pkg::DEV_IDLE: begin
                if (go_conv) begin
                    nxt_state = tcr_pkg::DEV_CONV; // RQ4
                    nxt_cnt = conv_len - 1'h1;
                    nxt_starved = 1'h0;
                end
            end
            tcr_pkg::DEV_CONV: begin
                if (starve) begin
                    nxt_state = tcr_pkg::DEV_IDLE;
                    nxt_starved = 1'h1;
                end else if (conv_end) begin
                    nxt_state = tcr_pkg::DEV_IDLE; // RQ5
                    nxt_result = fresh; // RQ5
                end else begin
                    nxt_cnt = cnt_ff - 1'h1;
                end
            end
            default: begin
                nxt_state = tcr_pkg::DEV_IDLE;
            end
        endcase
    end

    // Slot answers; a convert or read command in the same cycle as a slot wins
    always_comb begin
        nxt_ans = ans_ff;
        nxt_bit = bit_ff;
        nxt_oe = 1'h0;
        if (go_conv) begin
            nxt_ans = tcr_pkg::ANS_BUSY;
        end else if (go_read) begin
            nxt_ans = tcr_pkg::ANS_DATA;
            nxt_bit = '0;
        end else if (link.slot) begin
            case (ans_ff)
                tcr_pkg::ANS_BUSY: begin
                    // Line-powered parts stay silent while converting
                    nxt_oe = ~is_idle & ~line_pwr_ff; // RQ6
                end
                tcr_pkg::ANS_DATA: begin
                    nxt_oe = ~frame[bit_ff];
                    nxt_bit = bit_ff + 1'h1;
                    if (bit_ff == `TCR_FRAME_LAST) begin
                        nxt_ans = tcr_pkg::ANS_NONE;
                    end
                end
                default: begin
                    nxt_oe = 1'h0;
                end
            endcase
        end
    end

    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state_ff <= tcr_pkg::DEV_IDLE; // RQ3
            cnt_ff <= '0;
            result_ff <= `TCR_RESULT_RST; // RQ16
            starved_ff <= 1'h0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            result_ff <= nxt_result;
            starved_ff <= nxt_starved;
        end
    end

    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ans_ff <= tcr_pkg::ANS_NONE;
            bit_ff <= '0;
            oe_ff <= 1'h0;
        end else begin
            ans_ff <= nxt_ans;
            bit_ff <= nxt_bit;
            oe_ff <= nxt_oe;
        end
    end

    // Open-drain: only ever pull low or release
    assign link.dev_dq_o = 1'h0; // RQ15
    assign link.dev_dq_oe = oe_ff; // RQ15

    assign converting_out = ~is_idle;
    assign line_powered_out = line_pwr_ff;
    assign starved_out = starved_ff;
    assign resolution_out = res;
    assign temperature_result_out = result_ff;
endmodule
`default_nettype wire

// *** core/tcr_host.sv ***
// Bus master end: AXI4-Lite register file driving conversions and reads
//
// Decided for this implementation: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "tcr_map.svh"
module tcr_host #(
    parameter int CONV_CYCLES = `TCR_TCONV_MS * `TCR_CLK_KHZ,
    parameter int CNT_W = 24
) (
    // Clock and reset
    input wire logic clock_in,
    input wire logic reset_n_in,
    // AXI4-Lite slave
    input wire logic [7:0] s_axi_awaddr_in,
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    output logic [1:0] s_axi_bresp_out,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    input wire logic [7:0] s_axi_araddr_in,
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    // Interrupt
    output logic irq_out,
    // Link
    tcr_link_if.host link
);
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (s[b]) r[b*8 +: 8] = d[b*8 +: 8];
        end
        return r;
    endfunction

    tcr_pkg::tcr_host_state_t st_ff;
    logic aw_full_ff, w_full_ff, bvalid_ff, rvalid_ff;
    logic [7:0] awaddr_ff;
    logic [31:0] wdata_ff, rdata_ff, id_lo_ff, id_hi_ff;
    logic [3:0] wstrb_ff;
    logic [1:0] bresp_ff, rresp_ff, int_stat_ff, int_mask_ff;
    logic linepwr_ff;
    logic [23:0] cfg_ff;
    logic [15:0] user_ff, rres_ff;
    logic [39:0] rnv_ff;
    logic [55:0] sh_ff;
    logic [5:0] rbit_ff;
    logic [CNT_W-1:0] cnt_ff;
    logic [7:0] code_ff;

    // Write channel decode
    wire do_wr = aw_full_ff & w_full_ff & ~bvalid_ff;
    wire a_ctrl = (awaddr_ff == `TCR_REG_CTRL);
    wire a_idlo = (awaddr_ff == `TCR_REG_ID_LO);
    wire a_idhi = (awaddr_ff == `TCR_REG_ID_HI);
    wire a_cfg = (awaddr_ff == `TCR_REG_CFG);
    wire a_user = (awaddr_ff == `TCR_REG_USER);
    wire a_mask = (awaddr_ff == `TCR_REG_INT_MASK);
    wire a_ro = (awaddr_ff == `TCR_REG_STATUS) | (awaddr_ff == `TCR_REG_RESULT)
              | (awaddr_ff == `TCR_REG_INT_STAT) | (awaddr_ff == `TCR_REG_NVRD);
    wire wr_hit = a_ctrl | a_idlo | a_idhi | a_cfg | a_user | a_mask | a_ro;
    wire [31:0] ctrl_wd = merge(32'h0, wdata_ff, wstrb_ff);
    wire idle = (st_ff == tcr_pkg::H_IDLE);
    wire wr_go = do_wr & a_ctrl & idle;
    wire go_conv = wr_go & ctrl_wd[`TCR_CTRL_CONV];
    wire go_read = wr_go & ctrl_wd[`TCR_CTRL_READ];
    wire go_wrcfg = wr_go & ctrl_wd[`TCR_CTRL_WRCFG];
    wire [7:0] go_code = go_conv ? `TCR_CMD_CONVERT :
                         go_read ? `TCR_CMD_READ : `TCR_CMD_WRCFG;

    // Read channel decode
    wire ar_take = s_axi_arvalid_in & ~rvalid_ff;
    wire [7:0] ra = s_axi_araddr_in;
    wire rd_istat = ar_take & (ra == `TCR_REG_INT_STAT);
    wire [31:0] rd_word =
        (ra == `TCR_REG_CTRL) ? {28'h0, linepwr_ff, 3'h0} :
        (ra == `TCR_REG_ID_LO) ? id_lo_ff :
        (ra == `TCR_REG_ID_HI) ? id_hi_ff :
        (ra == `TCR_REG_CFG) ? {8'h0, cfg_ff} :
        (ra == `TCR_REG_USER) ? {16'h0, user_ff} :
        (ra == `TCR_REG_STATUS) ? {31'h0, ~idle} :
        (ra == `TCR_REG_RESULT) ? {rnv_ff[39:24], rres_ff} :
        (ra == `TCR_REG_INT_STAT) ? {30'h0, int_stat_ff} :
        (ra == `TCR_REG_INT_MASK) ? {30'h0, int_mask_ff} :
        (ra == `TCR_REG_NVRD) ? {8'h0, rnv_ff[23:0]} : 32'h0;
    wire rd_hit = (ra <= `TCR_REG_NVRD) & (ra[1:0] == 2'h0);

    // Link events
    wire poll_done = (st_ff == tcr_pkg::H_PSAMP) & link.dq;
    wire spu_done = (st_ff == tcr_pkg::H_SPU) & (cnt_ff == '0);
    wire rd_last = (st_ff == tcr_pkg::H_RSAMP) & (rbit_ff == `TCR_FRAME_LAST);
    wire [1:0] ev = {rd_last, poll_done | spu_done};
    wire [55:0] sh_nxt = {link.dq, sh_ff[55:1]};

    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            aw_full_ff <= 1'h0;
            w_full_ff <= 1'h0;
            bvalid_ff <= 1'h0;
            awaddr_ff <= '0;
            wdata_ff <= '0;
            wstrb_ff <= '0;
            bresp_ff <= '0;
        end else begin
            if (s_axi_awvalid_in & s_axi_awready_out) begin
                aw_full_ff <= 1'h1;
                awaddr_ff <= s_axi_awaddr_in;
            end else if (do_wr) aw_full_ff <= 1'h0;
            if (s_axi_wvalid_in & s_axi_wready_out) begin
                w_full_ff <= 1'h1;
                wdata_ff <= s_axi_wdata_in;
                wstrb_ff <= s_axi_wstrb_in;
            end else if (do_wr) w_full_ff <= 1'h0;
            if (do_wr) begin
                bvalid_ff <= 1'h1;
                bresp_ff <= wr_hit ? 2'h0 : 2'h2;
            end else if (s_axi_bready_in) bvalid_ff <= 1'h0;
        end
    end

    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rvalid_ff <= 1'h0;
            rdata_ff <= '0;
            rresp_ff <= '0;
        end else if (ar_take) begin
            rvalid_ff <= 1'h1;
            rdata_ff <= rd_word;
            rresp_ff <= rd_hit ? 2'h0 : 2'h2;
        end else if (s_axi_rready_in) rvalid_ff <= 1'h0;
    end

    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            linepwr_ff <= 1'h0;
            id_lo_ff <= '0;
            id_hi_ff <= '0;
            cfg_ff <= `TCR_CFG_RST;
            user_ff <= '0;
            int_mask_ff <= '0;
            int_stat_ff <= '0;
        end else begin
            if (do_wr & a_ctrl) linepwr_ff <= ctrl_wd[`TCR_CTRL_LINEPWR];
            if (do_wr & a_idlo) id_lo_ff <= merge(id_lo_ff, wdata_ff, wstrb_ff);
            if (do_wr & a_idhi) id_hi_ff <= merge(id_hi_ff, wdata_ff, wstrb_ff);
            if (do_wr & a_cfg) cfg_ff <= 24'(merge({8'h0, cfg_ff}, wdata_ff, wstrb_ff));
            if (do_wr & a_user) user_ff <= 16'(merge({16'h0, user_ff}, wdata_ff, wstrb_ff));
            if (do_wr & a_mask) int_mask_ff <= ctrl_wd[1:0];
            // Set beats the read clear so no event is lost
            int_stat_ff <= (int_stat_ff & ~{2{rd_istat}}) | ev;
        end
    end

    // Link sequencer
    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            st_ff <= tcr_pkg::H_IDLE;
            code_ff <= '0;
            cnt_ff <= '0;
            rbit_ff <= '0;
            sh_ff <= '0;
            rres_ff <= '0;
            rnv_ff <= '0;
        end else begin
            case (st_ff)
                tcr_pkg::H_IDLE: begin
                    if (go_conv | go_read | go_wrcfg) begin
                        st_ff <= tcr_pkg::H_CMD;
                        code_ff <= go_code;
                    end
                end
                tcr_pkg::H_CMD: begin
                    rbit_ff <= '0;
                    cnt_ff <= CNT_W'(CONV_CYCLES - 1);
                    if (code_ff == `TCR_CMD_CONVERT) begin
                        st_ff <= linepwr_ff ? tcr_pkg::H_SPU : tcr_pkg::H_POLL; // RQ7
                    end else if (code_ff == `TCR_CMD_READ) begin
                        st_ff <= tcr_pkg::H_RSLOT;
                    end else st_ff <= tcr_pkg::H_IDLE;
                end
                tcr_pkg::H_POLL: st_ff <= tcr_pkg::H_PSAMP; // RQ6
                tcr_pkg::H_PSAMP: st_ff <= link.dq ? tcr_pkg::H_IDLE : tcr_pkg::H_POLL;
                tcr_pkg::H_SPU: begin
                    if (spu_done) st_ff <= tcr_pkg::H_IDLE;
                    else cnt_ff <= cnt_ff - 1'h1;
                end
                tcr_pkg::H_RSLOT: st_ff <= tcr_pkg::H_RSAMP;
                tcr_pkg::H_RSAMP: begin
                    sh_ff <= sh_nxt;
                    rbit_ff <= rbit_ff + 1'h1;
                    if (rd_last) begin
                        st_ff <= tcr_pkg::H_IDLE;
                        rres_ff <= sh_nxt[15:0];
                        rnv_ff <= sh_nxt[55:16];
                    end else st_ff <= tcr_pkg::H_RSLOT;
                end
                default: st_ff <= tcr_pkg::H_IDLE;
            endcase
        end
    end

    // Link drive; command fields are held in registers above
    assign link.cmd_valid = (st_ff == tcr_pkg::H_CMD); // RQ4
    assign link.cmd_code = code_ff; // RQ4
    assign link.cmd_id = {id_hi_ff, id_lo_ff}; // RQ14
    assign link.cmd_data = {user_ff, cfg_ff};
    assign link.slot = (st_ff == tcr_pkg::H_POLL) | (st_ff == tcr_pkg::H_RSLOT);
    // Pullup rises the cycle after the command and nothing else is sent meanwhile
    assign link.strong_pullup = (st_ff == tcr_pkg::H_SPU); // RQ17
    assign link.host_dq_o = 1'h0;
    assign link.host_dq_oe = link.slot;

    assign s_axi_awready_out = ~aw_full_ff & ~bvalid_ff;
    assign s_axi_wready_out = ~w_full_ff & ~bvalid_ff;
    assign s_axi_bvalid_out = bvalid_ff;
    assign s_axi_bresp_out = bresp_ff;
    assign s_axi_arready_out = ~rvalid_ff;
    assign s_axi_rvalid_out = rvalid_ff;
    assign s_axi_rdata_out = rdata_ff;
    assign s_axi_rresp_out = rresp_ff;
    assign irq_out = |(int_stat_ff & int_mask_ff);
endmodule
`default_nettype wire

// *** testbench/tcr_link_properties.sv ***
// Link timing checks between the bus master end and the thermometer end
`timescale 1ns/1ps
`default_nettype none
module tcr_link_properties #(
    parameter logic [63:0] DEV_ID = 64'h0
) (
    // Clock and reset
    input wire logic clock_in,
    input wire logic reset_n_in,
    // Link signals
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_code,
    input wire logic [63:0] cmd_id,
    input wire logic slot,
    input wire logic strong_pullup,
    input wire logic host_dq_o,
    input wire logic dev_dq_o,
    input wire logic dev_dq_oe
);
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!reset_n_in);
    wire conv_cmd = cmd_valid && cmd_code == 8'h44 && cmd_id == DEV_ID;

    cmd_pulse_a: assert property (cmd_valid |=> !cmd_valid)
        else $error("command strobe longer than one cycle");
    slot_pulse_a: assert property (slot |=> !slot)
        else $error("read slot longer than one cycle");
    open_drain_a: assert property (!dev_dq_o && !host_dq_o)
        else $error("data line driven high");
    answer_slot_a: assert property (dev_dq_oe |-> $past(slot))
        else $error("device pulls line outside a slot answer");
    answer_pulse_a: assert property (dev_dq_oe |=> !dev_dq_oe)
        else $error("device holds line low too long");
    pullup_quiet_a: assert property (strong_pullup |-> !slot && !cmd_valid)
        else $error("bus activity under strong pullup");
    pullup_cause_a: assert property ($rose(strong_pullup) |-> $past(cmd_code) == 8'h44)
        else $error("strong pullup without convert command");
    pullup_hold_a: assert property ($rose(strong_pullup) |=> strong_pullup [*8])
        else $error("strong pullup dropped early");
    busy_answer_a: assert property (conv_cmd ##1 slot |=> dev_dq_oe)
        else $error("busy slot not answered with 0");

    cover property (conv_cmd);
    cover property ($rose(strong_pullup));
    cover property (cmd_valid && cmd_code == 8'hbe);
endmodule
`default_nettype wire

// *** testbench/tb.sv ***
// Self-checking bench joining both ends of the temperature link
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam int CONV = 64;
    // Arbitrary identity value
    localparam logic [63:0] DEV_ID = 64'h0123456789abcdef;
    logic clock_in = 1'b0, reset_n_in = 1'b0, nv_reset_n_in = 1'b0, supply = 1'b1;
    logic [11:0] sensor_in = 12'h0;
    logic [7:0] awaddr = 8'h0, araddr = 8'h0;
    logic [31:0] wdata = 32'h0, rdata;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, irq, converting, lpwr, starved;
    logic [1:0] bresp, rresp, res;
    logic [15:0] temp;
    int err_count = 0, checks = 0, cycles = 0;

    tcr_link_if link();
    tcr_dev #(.DEV_ID(DEV_ID), .CONV_CYCLES(CONV)) i_tcr_dev (.clock_in(clock_in),
        .reset_n_in(reset_n_in), .nv_reset_n_in(nv_reset_n_in), .link(link),
        .sensor_in(sensor_in), .optional_supply_pin_in(supply), .converting_out(converting),
        .line_powered_out(lpwr), .starved_out(starved), .resolution_out(res),
        .temperature_result_out(temp));
    tcr_host #(.CONV_CYCLES(CONV)) i_tcr_host (.clock_in(clock_in), .reset_n_in(reset_n_in),
        .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
        .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(wvalid),
        .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
        .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
        .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
        .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready), .irq_out(irq), .link(link));
    tcr_link_properties #(.DEV_ID(DEV_ID)) i_props (.clock_in(clock_in),
        .reset_n_in(reset_n_in), .cmd_valid(link.cmd_valid), .cmd_code(link.cmd_code),
        .cmd_id(link.cmd_id), .slot(link.slot), .strong_pullup(link.strong_pullup),
        .host_dq_o(link.host_dq_o), .dev_dq_o(link.dev_dq_o), .dev_dq_oe(link.dev_dq_oe));

    always #12.5 clock_in = ~clock_in;
    // Whole run needs under two thousand cycles; the ceiling leaves a wide margin
    always @(posedge clock_in) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            err_count++;
            wrap_up();
        end
    end

    function automatic logic [15:0] exp_temp(input logic [11:0] s, input logic [1:0] r);
        logic [15:0] v;
        v = {{4{s[11]}}, s};
        return v & ~((16'h1 << (2'd3 - r)) - 16'h1);
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic pa = 1'b1;
        logic pw = 1'b1;
        logic done = 1'b0;
        logic [1:0] r;
        @(posedge clock_in);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!done) begin
            @(negedge clock_in);
            done = !pa && !pw && bvalid;
            pa = pa && !awready;
            pw = pw && !wready;
            r = bresp;
            @(posedge clock_in);
            awvalid <= pa;
            wvalid <= pw;
        end
        bready <= 1'b0;
        chk({30'h0, r}, {30'h0, er});
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rr);
        logic pa = 1'b1;
        logic done = 1'b0;
        @(posedge clock_in);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!done) begin
            @(negedge clock_in);
            done = !pa && rvalid;
            pa = pa && !arready;
            d = rdata;
            rr = rresp;
            @(posedge clock_in);
            arvalid <= pa;
        end
        rready <= 1'b0;
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic [1:0] rr;
        rd(a, d, rr);
        chk(d, exp);
    endtask

    // Busy rises on the same edge as the write response; still give it two cycles before polling
    task automatic idle();
        logic [31:0] d = 32'h1;
        logic [1:0] rr;
        repeat (2) @(posedge clock_in);
        while (d[0]) begin
            rd(8'h14, d, rr);
        end
    endtask

    task automatic wrap_up();
        $display("Checks %0d, errors %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        logic [31:0] d;
        logic [1:0] rr;
        logic [11:0] s;
        d = $urandom(21);
        repeat (16) @(posedge clock_in);
        reset_n_in <= 1'b1;
        nv_reset_n_in <= 1'b1;
        repeat (2) @(posedge clock_in);
        chk({31'h0, converting}, 32'h0);
        chk({30'h0, res}, 32'h3);
        chk({31'h0, lpwr}, 32'h0);
        chk({16'h0, temp}, 32'h0550);
        wr(8'h04, DEV_ID[31:0], 2'h0);
        wr(8'h08, DEV_ID[63:32], 2'h0);
        wr(8'h28, 32'h1, 2'h2);
        rd(8'h28, d, rr);
        chk({30'h0, rr}, 32'h2);
        wr(8'h20, 32'h1, 2'h0);
        // Sign boundaries first, random readings after
        for (int i = 0; i < 7; i++) begin
            s = (i == 0) ? 12'h800 : (i == 1) ? 12'h7ff : 12'($urandom);
            wr(8'h0c, {14'h0, i[1:0], 16'h807f}, 2'h0);
            wr(8'h00, 32'h4, 2'h0);
            idle();
            chk({30'h0, res}, {30'h0, i[1:0]});
            sensor_in <= s;
            wr(8'h00, 32'h1, 2'h0);
            idle();
            chk({31'h0, irq}, 32'h1);
            chk({16'h0, temp}, {16'h0, exp_temp(s, i[1:0])});
            rdchk(8'h1c, 32'h1);
            chk({31'h0, irq}, 32'h0);
            wr(8'h00, 32'h2, 2'h0);
            idle();
            chk({31'h0, irq}, 32'h0);
            rdchk(8'h18, {16'h0, exp_temp(s, i[1:0])});
            rdchk(8'h1c, 32'h2);
        end
        // Power cycle without clearing stored bytes, now powered from the line
        supply <= 1'b0;
        reset_n_in <= 1'b0;
        repeat (16) @(posedge clock_in);
        reset_n_in <= 1'b1;
        repeat (2) @(posedge clock_in);
        chk({16'h0, temp}, 32'h0550);
        chk({30'h0, res}, 32'h2);
        chk({31'h0, lpwr}, 32'h1);
        // Target code still zero after reset, so this convert must be ignored
        wr(8'h00, 32'h1, 2'h0);
        idle();
        chk({15'h0, converting, temp}, 32'h0550);
        wr(8'h04, DEV_ID[31:0], 2'h0);
        wr(8'h08, DEV_ID[63:32], 2'h0);
        s = 12'($urandom);
        sensor_in <= s;
        wr(8'h00, 32'h9, 2'h0);
        idle();
        chk({16'h0, temp}, {16'h0, exp_temp(s, 2'd2)});
        chk({31'h0, starved}, 32'h0);
        wrap_up();
    end
endmodule
`default_nettype wire
